// ==== hw/ips_if.sv ====
// message link between the sending unit and a receiving unit
`timescale 1ns/10ps
interface ips_if;
  logic valid;
  logic ready;
  logic [7:0] vector;
  logic [2:0] dtype;
  logic logical;
  logic level;
  logic trigger;
  logic [7:0] dest;
  logic [7:0] src;
  logic excl_src;

  modport dev
  (
    output valid, vector, dtype, logical, level, trigger, dest, src, excl_src,
    input ready
  );
  modport rcv
  (
    input valid, vector, dtype, logical, level, trigger, dest, src, excl_src,
    output ready
  );
endinterface

// ==== hw/ips_msg_build.sv ====
// turns the command halves into the message that goes on the link
`timescale 1ns/10ps
module ips_msg_build
(
  input wire logic [31:0] cmd_low,
  input wire logic [31:0] cmd_high,
  output logic [7:0] msg_vector,
  output logic [2:0] msg_dtype,
  output logic msg_logical,
  output logic msg_level,
  output logic msg_trigger,
  output logic [7:0] msg_dest,
  output logic msg_excl_src,
  output logic msg_self
);
  wire [2:0] dtype = cmd_low[ips_pkg::DTYPE_LSB +: 3];
  wire [1:0] shorthand = cmd_low[ips_pkg::SHORT_LSB +: 2];
  wire [7:0] dest_field = cmd_high[ips_pkg::DEST_LSB +: 8];
  wire lvl_flag = cmd_low[ips_pkg::LEVEL_BIT];
  wire trig_flag = cmd_low[ips_pkg::TRIG_BIT];

  // ==========================================================================
  // message kind
  // synchronisation: restart type with level flag clear
  wire is_sync = (dtype == ips_pkg::DT_RESTART) && !lvl_flag; // [RL9]
  wire sh_none = shorthand == ips_pkg::SH_NONE;
  wire sh_self = shorthand == ips_pkg::SH_SELF;
  wire sh_excl = shorthand == ips_pkg::SH_ALL_EXCL;
  wire sh_bcast = (shorthand == ips_pkg::SH_ALL_INCL) || sh_excl;

  // ==========================================================================
  // field translation
  // non-maskable carries no vector, so the field is dropped on the way out
  assign msg_vector = (dtype == ips_pkg::DT_NMI) ? 8'h00 : cmd_low[ips_pkg::VEC_LSB +: 8]; // [RL7]
  assign msg_dtype = dtype; // [RL4] [RL5] [RL8] [RL11]
  // sync, broadcasts and self messages are physical; otherwise the mode bit picks physical or logical
  assign msg_logical = (is_sync || sh_bcast || sh_self) ? 1'b0 : cmd_low[ips_pkg::DMODE_BIT]; // [RL12] [RL19] [RL21]
  // level is always issued as 1 except the sync de-assert message
  assign msg_level = !is_sync; // [RL14]
  // trigger only means anything on sync; level requests degrade to edge
  assign msg_trigger = is_sync ? trig_flag : 1'b0; // [RL15] [RL24]
  // destination field is consulted only with no shorthand
  assign msg_dest = (is_sync || sh_bcast) ? ips_pkg::DEST_BCAST : dest_field; // [RL16] [RL18] [RL19] [RL20]
  assign msg_excl_src = sh_excl && !is_sync; // [RL19]
  // self messages go on the link and come back by snooping
  assign msg_self = sh_self && !is_sync && !sh_none; // [RL17]
endmodule

// ==== hw/ips_pkg.sv ====
// constants shared by the cross-processor interrupt sender, receiver and link
package ips_pkg;
  // ==========================================================================
  // register map: byte addresses of the two command halves
  localparam logic [31:0] ADDR_CMD_LOW = 32'hFFE0_0300;
  localparam logic [31:0] ADDR_CMD_HIGH = 32'hFFE0_0310;

  // ==========================================================================
  // low half field positions
  localparam int VEC_LSB = 0;
  localparam int DTYPE_LSB = 8;
  localparam int DMODE_BIT = 11;
  localparam int STATUS_BIT = 12;
  localparam int LEVEL_BIT = 14;
  localparam int TRIG_BIT = 15;
  localparam int SHORT_LSB = 18;
  // high half: destination sits in bits 63..56 of the whole command
  localparam int DEST_LSB = 24;

  // writable bits; the status bit and reserved bits are excluded
  localparam logic [31:0] LOW_RW_MASK = 32'h000C_CFFF;
  localparam logic [31:0] HIGH_RW_MASK = 32'hFF00_0000;
  localparam logic [31:0] LOW_RESET = 32'h0000_0000;
  localparam logic [31:0] HIGH_RESET = 32'h0000_0000;

  // ==========================================================================
  // delivery types
  localparam logic [2:0] DT_FIXED = 3'h0;
  localparam logic [2:0] DT_LOWEST = 3'h1;
  localparam logic [2:0] DT_SYSMGMT = 3'h2;
  localparam logic [2:0] DT_RSVD = 3'h3;
  localparam logic [2:0] DT_NMI = 3'h4;
  localparam logic [2:0] DT_RESTART = 3'h5;
  localparam logic [2:0] DT_STARTUP = 3'h6;

  // destination shorthands
  localparam logic [1:0] SH_NONE = 2'h0;
  localparam logic [1:0] SH_SELF = 2'h1;
  localparam logic [1:0] SH_ALL_INCL = 2'h2;
  localparam logic [1:0] SH_ALL_EXCL = 2'h3;

  localparam logic [7:0] DEST_BCAST = 8'hFF;
  localparam logic [7:0] ARBITRATION_IDENTIFIER_RESET = 8'h00;

  typedef enum logic {SND_IDLE, SND_PEND} ips_snd_e;
endpackage

// ==== hw/ips_receiver.sv ====
// receiving end: takes link messages addressed to this unit
`timescale 1ns/10ps
module ips_receiver
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [7:0] unit_id,
  input wire logic hold,
  input wire logic prio_lowest,
  output logic take,
  output logic [7:0] take_vector,
  output logic [2:0] take_dtype,
  output logic take_logical,
  output logic [7:0] take_dest,
  output logic take_sync,
  output logic [7:0] arbitration_identifier,
  ips_if.rcv link
);
  // ==========================================================================
  // addressing
  wire accepted = link.valid && link.ready;
  // sync is recognised from the level flag the sender issues as 0
  wire is_sync = (link.dtype == ips_pkg::DT_RESTART) && !link.level; // [RL9] [RL10] [RL14]
  wire own_src = link.excl_src && (link.src == unit_id); // [RL19]
  wire phys_hit = (link.dest == unit_id) || (link.dest == ips_pkg::DEST_BCAST); // [RL18] [RL20]
  // logical matching is outside this unit; the user side filters it
  wire addr_hit = link.logical ? 1'b1 : phys_hit; // [RL21]
  wire prio_ok = (link.dtype != ips_pkg::DT_LOWEST) || prio_lowest; // [RL5]
  wire hit = is_sync || (!own_src && addr_hit && prio_ok);

  // ==========================================================================
  // back-pressure and delivery to the user side
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.ready <= 1'b0;
      take <= 1'b0;
      take_vector <= 8'h00;
      take_dtype <= ips_pkg::DT_FIXED;
      take_logical <= 1'b0;
      take_dest <= 8'h00;
      take_sync <= 1'b0;
      arbitration_identifier <= ips_pkg::ARBITRATION_IDENTIFIER_RESET;
    end
    else if (ce)
    begin
      link.ready <= !hold;
      take <= accepted && hit;
      if (accepted && hit)
      begin
        take_vector <= link.vector; // [RL6] [RL7]
        take_dtype <= link.dtype; // [RL8] [RL11]
        take_logical <= link.logical;
        take_dest <= link.dest;
        take_sync <= is_sync;
      end
      if (accepted && is_sync)
      begin
        arbitration_identifier <= unit_id; // [RL9]
      end
    end
  end
endmodule

// ==== hw/ips_sender.sv ====
// sending end: command register on apb, launches messages onto the link
// Function
// (RL1) writing low half launches a message
// (RL2) command reachable as two 32-bit halves
// (RL3) all fields writable except read-only status
// (RL4) three-bit delivery type decoded as listed
// (RL5) fixed delivers vector; lowest picks idlest target
// (RL6) software writes zero vector for management/restart
// (RL7) non-maskable ignores the vector field
// (RL8) restart request resets every addressed processor
// (RL9) sync message reaches all units, copying identifiers
// (RL10) software: sync uses level 0, trigger 1
// (RL11) start-up sent once, never retried
// (RL12) mode bit: 0 physical, 1 logical
// (RL13) status 1 while latest message unsent
// (RL14) level issued 1 except sync de-assert
// (RL15) trigger only meaningful for sync, else 0
// (RL16) shorthand 00 uses destination field
// (RL17) shorthand 01 targets the sender only
// (RL18) shorthand 10 broadcasts with all-ones destination
// (RL19) shorthand 11 excludes sender, physical all-ones
// (RL20) destination bits 63..56 used without shorthand
// (RL21) logical destinations interpreted by receivers
// (RL22) software programs only valid edge combinations
// (RL23) status set on launch, cleared on acceptance
// (RL24) level trigger overridden to edge
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
module ips_sender
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] unit_id,
  output logic send_pending,
  ips_if.dev link
);
  // merge write data into a register under the byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] cmd_low;
  logic [31:0] cmd_high;
  ips_pkg::ips_snd_e state;
  ips_pkg::ips_snd_e next_state;

  // ==========================================================================
  // bus decode
  wire sel_low = paddr == ips_pkg::ADDR_CMD_LOW; // [RL2]
  wire sel_high = paddr == ips_pkg::ADDR_CMD_HIGH; // [RL2]
  wire mapped = sel_low || sel_high;
  wire pending = state == ips_pkg::SND_PEND;
  // a low write while a message is unsent waits, so no message is lost
  wire low_stall = sel_low && pwrite && pending;
  wire access = psel && penable;
  wire next_pready = access && !pready && !low_stall;
  wire done = access && pready;
  wire wr_low = done && pwrite && sel_low; // [RL1]
  wire wr_high = done && pwrite && sel_high; // [RL1]
  wire [31:0] new_low = strb_merge(cmd_low, pwdata, pstrb) & ips_pkg::LOW_RW_MASK; // [RL3]
  wire [31:0] new_high = strb_merge(cmd_high, pwdata, pstrb) & ips_pkg::HIGH_RW_MASK; // [RL3]
  // status reads back from live state; writes to it are masked off above
  wire [31:0] low_view = cmd_low | ({31'h0, pending} << ips_pkg::STATUS_BIT); // [RL13]
  wire [31:0] rd_value = sel_low ? low_view : (sel_high ? cmd_high : 32'h0000_0000);
  wire accepted = link.valid && link.ready;

  // ==========================================================================
  // message construction from the freshly written low half
  wire [7:0] b_vector;
  wire [2:0] b_dtype;
  wire b_logical;
  wire b_level;
  wire b_trigger;
  wire [7:0] b_dest;
  wire b_excl;
  wire b_self;

  ips_msg_build u_build
  (
    .cmd_low(new_low),
    .cmd_high(cmd_high),
    .msg_vector(b_vector),
    .msg_dtype(b_dtype),
    .msg_logical(b_logical),
    .msg_level(b_level),
    .msg_trigger(b_trigger),
    .msg_dest(b_dest),
    .msg_excl_src(b_excl),
    .msg_self(b_self)
  );

  // self target becomes a physical message to our own identifier
  wire [7:0] launch_dest = b_self ? unit_id : b_dest; // [RL17]

  // ==========================================================================
  // send state: launch sets pending, acceptance clears it
  always_comb
  begin
    next_state = state;
    unique case (state)
      ips_pkg::SND_IDLE:
      begin
        if (wr_low)
        begin
          next_state = ips_pkg::SND_PEND; // [RL23]
        end
      end
      ips_pkg::SND_PEND:
      begin
        // one attempt only; a failed start-up is software's to redo
        if (accepted)
        begin
          next_state = ips_pkg::SND_IDLE; // [RL11] [RL23]
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ips_pkg::SND_IDLE;
      send_pending <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      send_pending <= next_state == ips_pkg::SND_PEND; // [RL13]
    end
  end

  // ==========================================================================
  // command register halves
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_low <= ips_pkg::LOW_RESET;
      cmd_high <= ips_pkg::HIGH_RESET;
    end
    else if (ce)
    begin
      if (wr_low)
      begin
        cmd_low <= new_low; // [RL3]
      end
      if (wr_high)
      begin
        cmd_high <= new_high; // [RL3]
      end
    end
  end

  // ==========================================================================
  // apb answer: one wait cycle, longer while a low write is held off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready <= next_pready;
      pslverr <= next_pready && !mapped;
      prdata <= (next_pready && !pwrite) ? rd_value : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // link outputs, held stable until the receiver takes them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.valid <= 1'b0;
      link.vector <= 8'h00;
      link.dtype <= ips_pkg::DT_FIXED;
      link.logical <= 1'b0;
      link.level <= 1'b1;
      link.trigger <= 1'b0;
      link.dest <= 8'h00;
      link.src <= 8'h00;
      link.excl_src <= 1'b0;
    end
    else if (ce)
    begin
      if (accepted)
      begin
        link.valid <= 1'b0; // [RL23]
      end
      // launch is checked last so a set can never be lost to a clear
      if (wr_low)
      begin
        link.valid <= 1'b1; // [RL1] [RL5] [RL8]
        link.vector <= b_vector; // [RL7]
        link.dtype <= b_dtype; // [RL4]
        link.logical <= b_logical; // [RL12]
        link.level <= b_level; // [RL14]
        link.trigger <= b_trigger; // [RL15] [RL24]
        link.dest <= launch_dest; // [RL16] [RL20]
        link.src <= unit_id;
        link.excl_src <= b_excl; // [RL19]
      end
    end
  end
endmodule

// ==== verif/interprocessor_command_sender_tb.sv ====
// bench joining the sending and receiving ends over the message link
`timescale 1ns/10ps
module interprocessor_command_sender_tb;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, hold = 0, prio = 1;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] sid = 8'h03, rid = 8'h05, take_vector, arbitration_identifier, take_dest;
  logic pready, pslverr, send_pending, take, take_sync, e, take_logical;
  logic [2:0] take_dtype;
  int n_mismatch = 0, comparisons = 0;
  ips_if link();
  ips_sender u_ips_sender(.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .unit_id(sid), .send_pending(send_pending), .link(link));
  ips_receiver u_ips_receiver(.pclk(pclk), .presetn(presetn), .ce(ce), .unit_id(rid), .hold(hold),
    .prio_lowest(prio), .take(take), .take_vector(take_vector), .take_dtype(take_dtype), .take_logical(take_logical),
    .take_dest(take_dest), .take_sync(take_sync), .arbitration_identifier(arbitration_identifier), .link(link));
  ips_link_monitor u_ips_link_monitor(.pclk(pclk), .presetn(presetn), .valid(link.valid), .ready(link.ready),
    .vector(link.vector), .dtype(link.dtype), .logical(link.logical), .level(link.level),
    .trigger(link.trigger), .dest(link.dest), .src(link.src), .excl_src(link.excl_src));
  // 125 MHz clock
  always #4 pclk = ~pclk;
  // ==========================================================================
  // helpers
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      n_mismatch++;
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task give_up;
    n_mismatch++;
    final_report;
  endtask
  // one apb transfer; the request stands until the edge that samples pready high,
  // and read data and error are taken at that same edge
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 99);
    if (pready !== 1'b1) give_up;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // lets the receiver take the waiting message
  task release_link;
    int n;
    @(posedge pclk) hold <= 1'b0;
    for (n = 0; n < 99 && link.valid !== 1'b0; n++) @(posedge pclk) #1;
    if (n >= 99) give_up;
  endtask
  function automatic logic [31:0] lw(logic [7:0] v, logic [2:0] dt, logic dm, lv, tr, logic [1:0] sh);
    return {12'h000, sh, 2'h0, tr, lv, 2'h0, dm, dt, v};
  endfunction
  function automatic logic [31:0] lk(logic [7:0] v, logic [2:0] dt, logic lg, lv, tr, logic [7:0] d, logic x);
    return {9'h000, v, dt, lg, lv, tr, d, x};
  endfunction
  // sends one command with the receiver stalled, checks the wire, then the take
  task fire(input logic [31:0] lo, input logic [7:0] d, input logic [31:0] el, input logic et, input logic [7:0] ev);
    @(posedge pclk) hold <= 1'b1;
    apb(1'b1, ips_pkg::ADDR_CMD_HIGH, {d, 24'h000000});
    apb(1'b1, ips_pkg::ADDR_CMD_LOW, lo);
    #1;
    chk(32'({link.valid, send_pending}), 32'h3);
    chk(lk(link.vector, link.dtype, link.logical, link.level, link.trigger, link.dest, link.excl_src), el);
    chk(32'(link.src), 32'(sid));
    release_link;
    chk(32'(send_pending), 32'h0);
    // take rises at the accepting edge and stands one cycle, so look now
    chk(32'(take), 32'(et));
    if (et)
    begin
      chk(32'({take_vector, take_dtype}), 32'({ev, el[14:12]}));
      chk(32'({take_logical, take_dest}), 32'({el[11], el[8:1]}));
    end
  endtask
  // ==========================================================================
  // scenarios
  task t_regs;
    apb(1'b0, ips_pkg::ADDR_CMD_LOW, 32'h0);
    chk(r, 32'h0000_0000);
    apb(1'b0, 32'hFFE0_0320, 32'h0);
    chk(r, 32'h0000_0000);
    chk(32'(e), 32'h1);
    @(posedge pclk) hold <= 1'b1;
    apb(1'b1, ips_pkg::ADDR_CMD_HIGH, 32'hFFFF_FFFF);
    apb(1'b1, ips_pkg::ADDR_CMD_LOW, 32'hFFFF_F0AB);
    apb(1'b0, ips_pkg::ADDR_CMD_LOW, 32'h0);
    chk(r, 32'h000C_D0AB);
    apb(1'b0, ips_pkg::ADDR_CMD_HIGH, 32'h0);
    chk(r, 32'hFF00_0000);
    // with the enable low nothing may move, not even an offered ready
    @(posedge pclk) ce <= 1'b0;
    repeat (4) @(posedge pclk) hold <= 1'b0;
    #1;
    chk(32'({link.valid, send_pending, link.ready}), 32'h6);
    @(posedge pclk) ce <= 1'b1;
    release_link;
    apb(1'b0, ips_pkg::ADDR_CMD_LOW, 32'h0);
    chk(r, 32'h000C_C0AB);
    $display("test regs done");
  endtask
  task t_high_only;
    apb(1'b1, ips_pkg::ADDR_CMD_HIGH, 32'h0500_0000);
    repeat (4)
    begin
      @(posedge pclk) #1;
      chk(32'({link.valid, send_pending}), 32'h0);
    end
    $display("test high only done");
  endtask
  task t_dest;
    fire(lw(8'h41, 3'h0, 1'b0, 1'b1, 1'b0, 2'h0), 8'h05,
      lk(8'h41, 3'h0, 1'b0, 1'b1, 1'b0, 8'h05, 1'b0), 1'b1, 8'h41);
    fire(lw(8'h42, 3'h0, 1'b0, 1'b1, 1'b0, 2'h0), 8'h09,
      lk(8'h42, 3'h0, 1'b0, 1'b1, 1'b0, 8'h09, 1'b0), 1'b0, 8'h00);
    fire(lw(8'h43, 3'h0, 1'b1, 1'b1, 1'b0, 2'h0), 8'h0C,
      lk(8'h43, 3'h0, 1'b1, 1'b1, 1'b0, 8'h0C, 1'b0), 1'b1, 8'h43);
    // self and all-including-self are programmed with fixed delivery only
    fire(lw(8'h44, 3'h0, 1'b1, 1'b1, 1'b0, 2'h1), 8'h05,
      lk(8'h44, 3'h0, 1'b0, 1'b1, 1'b0, 8'h03, 1'b0), 1'b0, 8'h00);
    fire(lw(8'h45, 3'h0, 1'b0, 1'b1, 1'b0, 2'h2), 8'h09,
      lk(8'h45, 3'h0, 1'b0, 1'b1, 1'b0, 8'hFF, 1'b0), 1'b1, 8'h45);
    $display("test destinations done");
  endtask
  // every usable type, sent to all but the sender
  task t_types;
    logic [2:0] dts [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    logic [7:0] v;
    logic [7:0] ev;
    logic tr;
    for (int i = 0; i < 6; i++)
    begin
      v = (dts[i] == 3'h2 || dts[i] == 3'h5) ? 8'h00 : 8'h70;
      ev = (dts[i] == 3'h4) ? 8'h00 : v;
      // level trigger set on fixed, lowest and non-maskable only; the device overrides it to edge on every type here
      tr = dts[i] == 3'h0 || dts[i] == 3'h1 || dts[i] == 3'h4;
      fire(lw(v, dts[i], 1'b0, 1'b1, tr, 2'h3), 8'h05,
        lk(ev, dts[i], 1'b0, 1'b1, 1'b0, 8'hFF, 1'b1), 1'b1, ev);
    end
    $display("test types done");
  endtask
  task t_sync;
    chk(32'(arbitration_identifier), 32'h0);
    // sync programmed with level 0, trigger 1 and the all-including-self shorthand
    fire(lw(8'h00, 3'h5, 1'b0, 1'b0, 1'b1, 2'h2), 8'h33,
      lk(8'h00, 3'h5, 1'b0, 1'b0, 1'b1, 8'hFF, 1'b0), 1'b1, 8'h00);
    chk(32'({take_sync, arbitration_identifier}), 32'h105);
    $display("test sync done");
  endtask
  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_high_only;
    t_dest;
    t_types;
    t_sync;
    final_report;
  end
endmodule

// ==== verif/ips_link_monitor.sv ====
// concurrent checks on the message link between the two ends
`timescale 1ns/10ps
module ips_link_monitor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic valid,
  input wire logic ready,
  input wire logic [7:0] vector,
  input wire logic [2:0] dtype,
  input wire logic logical,
  input wire logic level,
  input wire logic trigger,
  input wire logic [7:0] dest,
  input wire logic [7:0] src,
  input wire logic excl_src
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // handshake: a waiting message must not change under the receiver
  a_msg_held_whole: assert property (valid && !ready |=> valid
    && $stable({vector, dtype, logical, level, trigger, dest, src, excl_src}))
    else $error("message changed while waiting");
  a_valid_drops_taken: assert property (valid && ready |=> !valid) else $error("valid held after accept");
  // ==========================================================================
  // message translation
  a_nmi_vector_zero: assert property (valid && dtype == ips_pkg::DT_NMI |-> vector == 8'h00)
    else $error("vector sent with nmi");
  a_level_not_sync: assert property (valid && dtype != ips_pkg::DT_RESTART |-> level)
    else $error("level low on plain message");
  a_trigger_edge_only: assert property (valid && level |-> !trigger)
    else $error("level trigger issued");
  a_sync_to_all: assert property (valid && !level |-> dest == 8'hFF && !logical && !excl_src)
    else $error("sync not broadcast");
  a_excl_phys_bcast: assert property (valid && excl_src |-> dest == 8'hFF && !logical)
    else $error("exclude-self not physical broadcast");
  a_logical_no_short: assert property (valid && logical |-> !excl_src && level)
    else $error("logical mode with shorthand");
  // main scenarios seen on the wire
  c_sync: cover property (valid && ready && !level);
  c_nmi: cover property (valid && ready && dtype == ips_pkg::DT_NMI);
  c_excl: cover property (valid && ready && excl_src);
endmodule
